// ---- hw/ewsg_top.sv ----
// Wait-state generator for the external program, data and I/O bus
//
// Operation
// - stretch each read by up to 7 cycles, 14 when doubled, a write by one more
// - with every field zero the counter logic is clock-gated off except while a write is presented or counting
// - 16-bit configuration register at data address 0028h
// - five regions: two program halves, two data halves, all of I/O
// - field value is the number of wait states per access
// - fields: I/O 14-12, data 11-9 and 8-6, program 5-3 and 2-0
// - bit 15 moves program halves to 4M-word ranges on extended parts
// - doubler bit multiplies every field count by two, before the write cycle is added
// - doubler lives in a control register at data address 002Bh
// - decoded access loads field; nonzero raises not-ready, counter starts
// - not-ready holds until count is zero and ready is high
// - CPU stall combines counter ready with external ready
// - ready pin sampled once per machine cycle
// - ready heeded only at two or more counts, in the last wait cycle
// - reset loads every field with 111b, register value 7FFFh
// - read costs count plus one cycles, write one cycle more
// - without extended addressing bit 15 is read-only zero
`timescale 1ns/1ps
`default_nettype none
module ewsg_top
  import ewsg_pkg::*;
#(
  parameter bit HAS_XPA     = 1'b1,
  parameter bit HAS_DOUBLER = 1'b1,
  parameter int ADDR_W      = ewsg_pkg::EWSG_ADDR_W
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  input  wire logic              acc_req,
  input  wire logic [1:0]        acc_space,
  input  wire logic [ADDR_W-1:0] acc_addr,
  input  wire logic              acc_write,
  input  wire logic              ready_ext,
  output logic                   cpu_wait,
  output logic                   acc_done,
  output logic                   wsg_clk_en
);

  ewsg_top_state_t       s_r;
  ewsg_top_state_t       s_nxt;

  logic [EWSG_CNT_W-1:0] cnt_val;
  logic                  cnt_last;
  logic                  cnt_load;
  logic [EWSG_CNT_W-1:0] cnt_load_val;
  logic                  cnt_run;

  logic [2:0]            sel_fld;
  logic [EWSG_CNT_W-1:0] eff_cnt;
  logic                  prog_upper;
  logic                  data_upper;
  logic                  cfg_hit;
  logic                  ctrl_hit;
  logic                  any_nonzero;
  logic                  finish;

  if (ADDR_W < EWSG_ADDR_W) begin : g_bad_addr
    $error("ewsg_top: ADDR_W too narrow for the extended program range");
  end

  // Field extraction, used for decode and for the gating test
  function automatic logic [2:0] fld(input logic [15:0] cfg, input int pos);
    fld = cfg[pos +: EWSG_FLD_W];
  endfunction

  // Writable mask of the configuration register
  function automatic logic [15:0] cfg_mask(input bit extended_program_range_select);
    cfg_mask = extended_program_range_select ? 16'hFFFF : 16'h7FFF;
  endfunction

  ewsg_wait_counter #(
    .CNT_W    (EWSG_CNT_W)
  ) u_cnt (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .run      (cnt_run),
    .load     (cnt_load),
    .load_val (cnt_load_val),
    .count    (cnt_val),
    .last     (cnt_last)
  );

  // Region decode for the pending access
  always_comb begin
    if (HAS_XPA && s_r.cfg[EWSG_XPA_BIT]) begin
      prog_upper = acc_addr[EWSG_XHALF_BIT];
    end else begin
      prog_upper = acc_addr[EWSG_HALF_BIT];
    end
    data_upper = acc_addr[EWSG_HALF_BIT];
    case (acc_space)
      EWSG_SP_PROG: begin
        sel_fld = prog_upper ? fld(s_r.cfg, EWSG_FLD_PROG_HI)
                             : fld(s_r.cfg, EWSG_FLD_PROG_LO);
      end
      EWSG_SP_DATA: begin
        sel_fld = data_upper ? fld(s_r.cfg, EWSG_FLD_DATA_HI)
                             : fld(s_r.cfg, EWSG_FLD_DATA_LO);
      end
      EWSG_SP_IO: begin
        sel_fld = fld(s_r.cfg, EWSG_FLD_IO);
      end
      default: begin
        sel_fld = fld(s_r.cfg, EWSG_FLD_IO);
      end
    endcase
  end

  // Effective count: field, doubled if asked, plus the write penalty
  always_comb begin
    eff_cnt = EWSG_CNT_W'(sel_fld);
    if (HAS_DOUBLER && s_r.dbl) begin
      eff_cnt = EWSG_CNT_W'({sel_fld, 1'b0});
    end
    if (acc_write) begin
      eff_cnt = eff_cnt + EWSG_CNT_W'(1);
    end
  end

  assign any_nonzero = (fld(s_r.cfg, EWSG_FLD_PROG_LO) != 3'h0)
                    || (fld(s_r.cfg, EWSG_FLD_PROG_HI) != 3'h0)
                    || (fld(s_r.cfg, EWSG_FLD_DATA_LO) != 3'h0)
                    || (fld(s_r.cfg, EWSG_FLD_DATA_HI) != 3'h0)
                    || (fld(s_r.cfg, EWSG_FLD_IO) != 3'h0);

  assign cfg_hit  = (reg_addr == EWSG_CFG_ADDR);
  assign ctrl_hit = HAS_DOUBLER && (reg_addr == EWSG_CTRL_ADDR);

  // Counter only steps while gated on; a write access with zero
  // fields still needs one cycle, so the gate also opens when busy.
  assign cnt_run  = s_r.clk_en && (s_r.st == EWSG_COUNT);

  always_comb begin
    s_nxt        = s_r;
    s_nxt.done   = 1'b0;
    s_nxt.rdata  = 16'h0000;
    cnt_load     = 1'b0;
    cnt_load_val = '0;
    finish       = 1'b0;

    // Register writes
    if (reg_wr && cfg_hit) begin
      // bit 15 read-only zero without extension
      s_nxt.cfg = reg_wdata & cfg_mask(HAS_XPA);
    end
    if (reg_wr && ctrl_hit) begin
      s_nxt.dbl = reg_wdata[EWSG_DBL_BIT];
    end

    // Register reads, data in the following cycle only
    if (reg_rd) begin
      if (cfg_hit) begin
        s_nxt.rdata = s_r.cfg & cfg_mask(HAS_XPA);
      end else if (ctrl_hit) begin
        s_nxt.rdata = {15'h0000, s_r.dbl};
      end
    end

    case (s_r.st)
      EWSG_IDLE: begin
        if (acc_req) begin
          // remember if ready pin is heeded
          s_nxt.hw_ok = (sel_fld >= EWSG_HW_RDY_MIN);
          if (eff_cnt != '0) begin
            cnt_load     = 1'b1;
            cnt_load_val = eff_cnt;
            s_nxt.st     = EWSG_COUNT;
            s_nxt.cpu_wait = 1'b1;
          end else begin
            s_nxt.done = 1'b1;
          end
        end
      end
      EWSG_COUNT: begin
        if (cnt_last || (cnt_val == '0)) begin
          // ready ignored before the last wait cycle
          if (s_r.hw_ok && !ready_ext) begin
            s_nxt.st = EWSG_HOLD;
          end else begin
            finish = 1'b1;
          end
        end
      end
      EWSG_HOLD: begin
        // release on zero count and ready high
        if (ready_ext) begin
          finish = 1'b1;
        end
      end
      default: begin
        s_nxt.st       = EWSG_IDLE;
        s_nxt.cpu_wait = 1'b0;
      end
    endcase

    if (finish) begin
      s_nxt.st       = EWSG_IDLE;
      s_nxt.cpu_wait = 1'b0;
      s_nxt.done     = 1'b1;
    end

    // gate counter clock when all fields are zero
    // A write only opens the gate while it is actually being presented
    s_nxt.clk_en = any_nonzero || (s_nxt.st != EWSG_IDLE) || (acc_req && acc_write);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_r.st       <= EWSG_IDLE;
      s_r.cfg      <= EWSG_CFG_RESET & cfg_mask(HAS_XPA);
      s_r.dbl      <= EWSG_CTRL_RESET[EWSG_DBL_BIT];
      s_r.rdata    <= 16'h0000;
      s_r.cpu_wait <= 1'b0;
      s_r.done     <= 1'b0;
      s_r.clk_en   <= 1'b1;
      s_r.hw_ok    <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cpu_wait   = s_r.cpu_wait;
  assign acc_done   = s_r.done;
  assign reg_rdata  = s_r.rdata;
  assign wsg_clk_en = s_r.clk_en;

endmodule
`default_nettype wire

// ---- hw/ewsg_pkg.sv ----
// Constants and types for the external bus wait-state generator
package ewsg_pkg;

  // Register word addresses in data space
  localparam logic [15:0] EWSG_CFG_ADDR    = 16'h0028;
  localparam logic [15:0] EWSG_CTRL_ADDR   = 16'h002B;

  // Reset values
  localparam logic [15:0] EWSG_CFG_RESET   = 16'h7FFF;
  localparam logic [15:0] EWSG_CTRL_RESET  = 16'h0000;

  // Register and field geometry
  localparam int          EWSG_REG_W       = 16;
  localparam int          EWSG_FLD_W       = 3;
  localparam int          EWSG_CNT_W       = 5;
  localparam int          EWSG_FLD_PROG_LO = 0;
  localparam int          EWSG_FLD_PROG_HI = 3;
  localparam int          EWSG_FLD_DATA_LO = 6;
  localparam int          EWSG_FLD_DATA_HI = 9;
  localparam int          EWSG_FLD_IO      = 12;
  localparam int          EWSG_XPA_BIT     = 15;
  localparam int          EWSG_DBL_BIT     = 0;

  // Address bits that split program and data space in halves
  localparam int          EWSG_HALF_BIT    = 15;
  localparam int          EWSG_XHALF_BIT   = 22;
  localparam int          EWSG_ADDR_W      = 23;

  // Least software count at which the ready pin is heeded
  localparam logic [2:0]  EWSG_HW_RDY_MIN  = 3'h2;

  // Address space codes on the access port
  localparam logic [1:0]  EWSG_SP_PROG     = 2'h0;
  localparam logic [1:0]  EWSG_SP_DATA     = 2'h1;
  localparam logic [1:0]  EWSG_SP_IO       = 2'h2;

  typedef enum logic [1:0] {
    EWSG_IDLE,
    EWSG_COUNT,
    EWSG_HOLD
  } ewsg_state_t;

  typedef struct packed {
    ewsg_state_t              st;
    logic [EWSG_REG_W-1:0]    cfg;
    logic                     dbl;
    logic [EWSG_REG_W-1:0]    rdata;
    logic                     cpu_wait;
    logic                     done;
    logic                     clk_en;
    logic                     hw_ok;
  } ewsg_top_state_t;

  typedef struct packed {
    logic [EWSG_CNT_W-1:0]    cnt;
  } ewsg_cnt_state_t;

endpackage

// ---- hw/ewsg_wait_counter.sv ----
// Down-counter for inserted wait states
`timescale 1ns/1ps
`default_nettype none
module ewsg_wait_counter
  import ewsg_pkg::*;
#(
  parameter int CNT_W = ewsg_pkg::EWSG_CNT_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic      [CNT_W-1:0] count,
  output logic                  last
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  if (CNT_W < 4) begin : g_bad_width
    $error("ewsg_wait_counter: CNT_W must hold a doubled count plus one");
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (run && (cnt_r != '0)) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count = cnt_r;
  assign last  = (cnt_r == CNT_W'(1));

endmodule
`default_nettype wire

// ---- dv/ewsg_slow_dev.sv ----
// Slow external memory model that drives the ready pin
`timescale 1ns/1ps
`default_nettype none
module ewsg_slow_dev (
  input  wire logic       clk_sys,
  input  wire logic       cpu_wait,
  input  wire logic [4:0] hold_cyc,
  output logic            ready_ext
);
  logic [4:0] k_r;
  always_ff @(posedge clk_sys)
    k_r <= cpu_wait ? k_r + 5'h01 : 5'h00;
  assign ready_ext = !cpu_wait || (k_r >= hold_cyc);
endmodule
`default_nettype wire

// ---- dv/ewsg_checker.sv ----
// Port assertions for the wait-state generator
`timescale 1ns/1ps
`default_nettype none
module ewsg_checker (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rd,
  input wire logic        acc_req,
  input wire logic        acc_write,
  input wire logic        ready_ext,
  input wire logic        cpu_wait,
  input wire logic        acc_done,
  input wire logic        wsg_clk_en
);
  logic [4:0] run_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Longest stretch with ready high is 14 doubled plus the write cycle
  always_ff @(posedge clk_sys)
    run_r <= (!rst_n || !cpu_wait || !ready_ext) ? 5'h00 : run_r + 5'h01;
  sequence s_take;
    acc_req && !cpu_wait;
  endsequence
  property p_take; s_take |=> cpu_wait || acc_done; endproperty
  property p_zero; s_take ##0 (!acc_write && !wsg_clk_en) |=> acc_done && !cpu_wait; endproperty
  property p_wstall; s_take ##0 acc_write |=> cpu_wait && !acc_done; endproperty
  property p_done1; acc_done && !acc_req |=> !acc_done; endproperty
  property p_clr; acc_done |-> !cpu_wait; endproperty
  property p_end; $fell(cpu_wait) |-> acc_done; endproperty
  property p_rd; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  property p_cap; run_r <= 5'h0F; endproperty
  property p_clk; cpu_wait |-> wsg_clk_en; endproperty
  a_take: assert property (p_take) else $error("access not taken");
  a_zero: assert property (p_zero) else $error("zero wait read stalled");
  a_wstall: assert property (p_wstall) else $error("write not stretched");
  a_done1: assert property (p_done1) else $error("done too long");
  a_clr: assert property (p_clr) else $error("done while stalled");
  a_end: assert property (p_end) else $error("stall ended without done");
  a_rd: assert property (p_rd) else $error("read data outside slot");
  a_cap: assert property (p_cap) else $error("stall beyond count");
  a_clk: assert property (p_clk) else $error("counter gated while busy");
endmodule
bind ewsg_top ewsg_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reg_rdata(reg_rdata),
  .reg_rd(reg_rd), .acc_req(acc_req), .acc_write(acc_write), .ready_ext(ready_ext),
  .cpu_wait(cpu_wait), .acc_done(acc_done), .wsg_clk_en(wsg_clk_en));
`default_nettype wire

// ---- dv/testbench.sv ----
// Directed test of the wait-state generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ewsg_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, acc_req = 1'b0, acc_write = 1'b0;
  logic [1:0]  acc_space = 2'h0;
  logic [22:0] acc_addr = 23'h000000;
  logic [4:0]  hold_cyc = 5'h00;
  logic        ready_ext, cpu_wait, acc_done, wsg_clk_en;
  int          err_total = 0, checked = 0;
  logic [1:0]  sp_t [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
  logic [22:0] ad_t [6] = '{23'h0000, 23'h8000, 23'h1234, 23'hF000, 23'hFFFF, 23'h0100};
  int          lat_t [6] = '{3, 2, 4, 5, 6, 6};
  always #2.5 clk_sys = ~clk_sys;
  ewsg_top u_ewsg_top (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_space(acc_space),
    .acc_addr(acc_addr), .acc_write(acc_write), .ready_ext(ready_ext), .cpu_wait(cpu_wait),
    .acc_done(acc_done), .wsg_clk_en(wsg_clk_en));
  ewsg_slow_dev u_ewsg_slow_dev (.clk_sys(clk_sys), .cpu_wait(cpu_wait), .hold_cyc(hold_cyc),
    .ready_ext(ready_ext));
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] exp, string nm);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(nm, exp, reg_rdata);
  endtask
  // Latency counts edges from the taking edge to the one that raises done
  task automatic acc(logic [1:0] sp, logic [22:0] ad, logic w, int lat, logic slow = 1'b0);
    int n;
    @(posedge clk_sys);
    acc_space <= sp;
    acc_addr <= ad;
    acc_write <= w;
    acc_req <= 1'b1;
    @(posedge clk_sys);
    acc_req <= 1'b0;
    #1 n = 1;
    chk("stall", 16'(lat > 1), 16'(cpu_wait));
    while (acc_done !== 1'b1 && n < 60) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (slow) begin
      chk("held", 16'h0001, 16'(n > lat));
    end else begin
      chk("latency", 16'(lat), 16'(n));
    end
  endtask
  task automatic results();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    $display("BAD watchdog exp done got hang");
    results();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(EWSG_CFG_ADDR, 16'h7FFF, "cfg_reset");
    rd(EWSG_CTRL_ADDR, 16'h0000, "ctrl_reset");
    rd(16'h0029, 16'h0000, "unmapped");
    acc(2'h2, 23'h0, 1'b0, 8);
    wr(EWSG_CFG_ADDR, 16'hFFFF);
    rd(EWSG_CFG_ADDR, 16'hFFFF, "cfg_all");
    wr(EWSG_CFG_ADDR, 16'h58CA);
    for (int i = 0; i < 6; i++) begin
      acc(sp_t[i], ad_t[i], 1'b0, lat_t[i]);
    end
    acc(2'h0, 23'h0, 1'b1, 4);
    hold_cyc <= 5'h14;
    acc(2'h0, 23'h8000, 1'b0, 2);
    acc(2'h2, 23'h0, 1'b0, 6, 1'b1);
    hold_cyc <= 5'h0A;
    acc(2'h0, 23'h0, 1'b0, 3, 1'b1);
    hold_cyc <= 5'h00;
    wr(EWSG_CTRL_ADDR, 16'hFFFF);
    rd(EWSG_CTRL_ADDR, 16'h0001, "ctrl_bits");
    acc(2'h1, 23'hF000, 1'b0, 9);
    wr(EWSG_CTRL_ADDR, 16'h0000);
    wr(EWSG_CFG_ADDR, 16'hD8CA);
    acc(2'h0, 23'h408000, 1'b0, 2);
    acc(2'h0, 23'h3F8000, 1'b0, 3);
    wr(EWSG_CFG_ADDR, 16'h0000);
    acc(2'h0, 23'h0, 1'b0, 1);
    acc(2'h1, 23'h0, 1'b1, 2);
    repeat (2) @(posedge clk_sys);
    #1 chk("clk_en", 16'h0000, 16'(wsg_clk_en));
    results();
  end
endmodule
`default_nettype wire
